// >>> src/pleb_core.sv
// Blanking core: state blanking and leading-edge delay counter.
// Assumes PWM outputs and sources are synchronous to clk.
`include "pleb_params.svh"
module pleb_core (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       high_side_output,
   input  wire logic       low_side_output,
   input  wire logic [2:0] gen_high_side,
   input  wire logic       fault_in,
   input  wire logic       climit_in,
   output logic            fault_qual,
   output logic            climit_qual,
   pleb_cfg_if.core        cfg
);
   import pleb_pkg::*;
   pleb_state_t state_reg, state_next;
   logic [11:0] cnt_reg, cnt_next;
   logic        h_d_reg, l_d_reg, fq_reg, fq_next, cq_reg, cq_next;
   logic        ext_src, src_valid, state_blank, edge_hit, leb_mask, mask;

   ////////////////////////////////////////////////////////////////
   // Blanking source select
   // Reserved codes act like no source, so the low-level enable cannot blank on them
   always_comb begin
      src_valid = 1'b1;
      case (cfg.source_sel) // see RL9
         `PLEB_SEL_GEN1: ext_src = gen_high_side[0];
         `PLEB_SEL_GEN2: ext_src = gen_high_side[1];
         `PLEB_SEL_GEN3: ext_src = gen_high_side[2];
         default: begin
            src_valid = 1'b0;
            ext_src   = 1'b0;
         end
      endcase
   end

   // State blanking from output levels and selected source
   assign state_blank = (cfg.en_lh &  low_side_output)   // see RL1
                      | (cfg.en_ll & ~low_side_output)   // see RL2
                      | (cfg.en_hl & ~high_side_output)  // see RL7
                      | (cfg.en_hh &  high_side_output)  // see RL8
                      | (src_valid &
                         ((cfg.sel_hi_en & ext_src) | (cfg.sel_lo_en & ~ext_src))); // see RL3

   // Enabled edges of either output
   assign edge_hit = (cfg.edge_en[3] &  high_side_output & ~h_d_reg)
                   | (cfg.edge_en[2] & ~high_side_output &  h_d_reg)
                   | (cfg.edge_en[1] &  low_side_output  & ~l_d_reg)
                   | (cfg.edge_en[0] & ~low_side_output  &  l_d_reg);

   ////////////////////////////////////////////////////////////////
   // Leading-edge counter state
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         PLEB_IDLE: begin
            if (edge_hit && cfg.delay != 12'h000) begin // see RL6
               state_next = PLEB_COUNT;
               cnt_next   = cfg.delay;
            end
         end
         PLEB_COUNT: begin
            if (edge_hit) begin
               cnt_next = cfg.delay; // see RL6
               if (cfg.delay == 12'h000) state_next = PLEB_IDLE;
            end else if (cnt_reg == 12'h001) begin
               state_next = PLEB_IDLE;
               cnt_next   = 12'h000;
            end else begin
               cnt_next = cnt_reg - 12'h001;
            end
         end
         default: begin
            state_next = PLEB_IDLE;
            cnt_next   = 12'h000;
         end
      endcase
   end

   assign leb_mask = (state_reg == PLEB_COUNT);
   assign mask     = leb_mask | state_blank;

   // Qualified outputs
   always_comb begin
      fq_next = fault_in & ~mask;
      cq_next = climit_in & ~mask;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= PLEB_IDLE;
         cnt_reg   <= 12'h000;
         h_d_reg   <= 1'b0;
         l_d_reg   <= 1'b0;
         fq_reg    <= 1'b0;
         cq_reg    <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         h_d_reg   <= high_side_output;
         l_d_reg   <= low_side_output;
         fq_reg    <= fq_next;
         cq_reg    <= cq_next;
      end
   end

   assign fault_qual       = fq_reg;
   assign climit_qual      = cq_reg;
   assign cfg.blank_active = state_blank;
   assign cfg.leb_active   = leb_mask;

   chk_lh_masks: assert property (@(posedge clk) disable iff (rst)
      cfg.en_lh && low_side_output |=> !fault_qual && !climit_qual) // see RL1
      else $error("low high blank failed");
   chk_ll_masks: assert property (@(posedge clk) disable iff (rst)
      cfg.en_ll && !low_side_output |=> !fault_qual) // see RL2
      else $error("low low blank failed");
   chk_hl_masks: assert property (@(posedge clk) disable iff (rst)
      cfg.en_hl && !high_side_output |=> !climit_qual) // see RL7
      else $error("high low blank failed");
   chk_hh_masks: assert property (@(posedge clk) disable iff (rst)
      cfg.en_hh && high_side_output |=> !fault_qual) // see RL8
      else $error("high high blank failed");
   chk_sel_none: assert property (@(posedge clk) disable iff (rst)
      cfg.source_sel == `PLEB_SEL_NONE && !cfg.en_ll && !cfg.en_lh && !cfg.en_hl
      && !cfg.en_hh |-> !state_blank) // see RL9
      else $error("blank without source");
   chk_sel_reserved: assert property (@(posedge clk) disable iff (rst) // see RL9
      cfg.source_sel > `PLEB_SEL_GEN3 && !cfg.en_ll && !cfg.en_lh && !cfg.en_hl
      && !cfg.en_hh |-> !state_blank)
      else $error("blank from reserved source");
   chk_sel_gen1: assert property (@(posedge clk) disable iff (rst)
      cfg.source_sel == `PLEB_SEL_GEN1 && cfg.sel_hi_en && gen_high_side[0]
      |-> state_blank) // see RL3
      else $error("source one not used");
   chk_leb_start: assert property (@(posedge clk) disable iff (rst)
      edge_hit && cfg.delay != 12'h000 |=> leb_mask && cnt_reg == $past(cfg.delay)) // see RL6
      else $error("blank interval not started");
   chk_leb_end: assert property (@(posedge clk) disable iff (rst)
      leb_mask && cnt_reg == 12'h001 && !edge_hit |=> !leb_mask) // see RL6
      else $error("blank interval not ended");
   chk_leb_gate: assert property (@(posedge clk) disable iff (rst)
      leb_mask |=> !fault_qual) // see RL4
      else $error("fault passed during blank");
endmodule // pleb_core

// >>> pkg/pleb_params.svh
// Constants for the leading-edge and state blanking block.
// Assumes a 16-bit register port with word indices as addresses.
// Functional notes
// RL1: Low-side-high enable masks inputs while low-side output is high.
// RL2: Bit 0 enable masks inputs while low-side output is low.
// RL3: Four-bit source select in aux control picks external blanking signal.
// RL4: Twelve-bit delay sets how long inputs are ignored after an edge.
// RL5: Upper four delay register bits read zero, writes ignored.
// RL6: Each enabled edge starts a count of delay clocks, then unmasks.
// RL7: Bit 2 enable masks inputs while high-side output is low.
// RL8: Bit 3 enable masks inputs while high-side output is high.
// RL9: Select 0 means none; 1, 2, 3 pick generators one to three high side.
`ifndef PLEB_PARAMS_SVH
`define PLEB_PARAMS_SVH
`define PLEB_ADDR_W        4
`define PLEB_OFS_CONTROL   4'h0
`define PLEB_OFS_DELAY     4'h1
`define PLEB_OFS_AUX       4'h2
`define PLEB_OFS_STATUS    4'h3
`define PLEB_BIT_LL        0
`define PLEB_BIT_LH        1
`define PLEB_BIT_HL        2
`define PLEB_BIT_HH        3
`define PLEB_BIT_SEL_HI    5
`define PLEB_BIT_SEL_LO    4
`define PLEB_BIT_RISE_H    15
`define PLEB_BIT_FALL_H    14
`define PLEB_BIT_RISE_L    13
`define PLEB_BIT_FALL_L    12
`define PLEB_CTRL_MASK     16'hf03f
`define PLEB_DELAY_MASK    16'h0fff
`define PLEB_AUX_MASK      16'h0f00
`define PLEB_SEL_LSB       8
`define PLEB_SEL_NONE      4'h0
`define PLEB_SEL_GEN1      4'h1
`define PLEB_SEL_GEN2      4'h2
`define PLEB_SEL_GEN3      4'h3
`endif

// >>> pkg/pleb_pkg.sv
// Types for the blanking block.
// Assumes the params header is compiled alongside.
package pleb_pkg;
   typedef enum logic [1:0] {
      PLEB_IDLE  = 2'b01,
      PLEB_COUNT = 2'b10
   } pleb_state_t;
   typedef logic [15:0] pleb_word_t;
endpackage

// >>> pkg/pleb_cfg_if.sv
// Configuration bundle passed from registers to the blanking core.
// Assumes one clock domain.
interface pleb_cfg_if;
   logic        en_ll;
   logic        en_lh;
   logic        en_hl;
   logic        en_hh;
   logic        sel_hi_en;
   logic        sel_lo_en;
   logic [3:0]  edge_en;
   logic [11:0] delay;
   logic [3:0]  source_sel;
   logic        blank_active;
   logic        leb_active;
   modport regs (output en_ll, en_lh, en_hl, en_hh, sel_hi_en, sel_lo_en, edge_en,
                 delay, source_sel, input blank_active, leb_active);
   modport core (input en_ll, en_lh, en_hl, en_hh, sel_hi_en, sel_lo_en, edge_en,
                 delay, source_sel, output blank_active, leb_active);
endinterface

// >>> src/pleb_regs.sv
// Register file for the blanking block.
// Assumes one-cycle strobes; read data valid the cycle after the strobe.
`include "pleb_params.svh"
module pleb_regs (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic [`PLEB_ADDR_W-1:0]   addr,
   input  wire pleb_pkg::pleb_word_t      wr_data,
   input  wire logic                      wr_en,
   input  wire logic                      rd_en,
   output pleb_pkg::pleb_word_t           rd_data,
   pleb_cfg_if.regs                       cfg
);
   import pleb_pkg::*;
   pleb_word_t ctrl_reg, ctrl_next, delay_reg, delay_next, aux_reg, aux_next;
   pleb_word_t rdata_reg, rdata_next;

   // Next-state of registers and read mux
   always_comb begin
      ctrl_next  = ctrl_reg;
      delay_next = delay_reg;
      aux_next   = aux_reg;
      rdata_next = 16'h0000;
      if (wr_en) begin
         case (addr)
            `PLEB_OFS_CONTROL: ctrl_next  = wr_data & `PLEB_CTRL_MASK;
            `PLEB_OFS_DELAY:   delay_next = wr_data & `PLEB_DELAY_MASK; // see RL5
            `PLEB_OFS_AUX:     aux_next   = wr_data & `PLEB_AUX_MASK;
            default: ;
         endcase
      end
      if (rd_en) begin
         case (addr)
            `PLEB_OFS_CONTROL: rdata_next = ctrl_reg;
            `PLEB_OFS_DELAY:   rdata_next = delay_reg; // see RL5
            `PLEB_OFS_AUX:     rdata_next = aux_reg;
            `PLEB_OFS_STATUS:  rdata_next = {14'h0000, cfg.leb_active, cfg.blank_active};
            default:           rdata_next = 16'h0000;
         endcase
      end
   end

   // Register update
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_reg  <= 16'h0000;
         delay_reg <= 16'h0000;
         aux_reg   <= 16'h0000;
         rdata_reg <= 16'h0000;
      end else begin
         ctrl_reg  <= ctrl_next;
         delay_reg <= delay_next;
         aux_reg   <= aux_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rd_data        = rdata_reg;
   assign cfg.en_ll      = ctrl_reg[`PLEB_BIT_LL];
   assign cfg.en_lh      = ctrl_reg[`PLEB_BIT_LH];
   assign cfg.en_hl      = ctrl_reg[`PLEB_BIT_HL];
   assign cfg.en_hh      = ctrl_reg[`PLEB_BIT_HH];
   assign cfg.sel_hi_en  = ctrl_reg[`PLEB_BIT_SEL_HI];
   assign cfg.sel_lo_en  = ctrl_reg[`PLEB_BIT_SEL_LO];
   assign cfg.edge_en    = ctrl_reg[`PLEB_BIT_RISE_H:`PLEB_BIT_FALL_L];
   assign cfg.delay      = delay_reg[11:0]; // see RL4
   assign cfg.source_sel = aux_reg[`PLEB_SEL_LSB+3:`PLEB_SEL_LSB]; // see RL3

   chk_delay_upper_zero: assert property (@(posedge clk) disable iff (rst)
      $past(rd_en) && $past(addr) == `PLEB_OFS_DELAY |-> rd_data[15:12] == 4'h0) // see RL5
      else $error("delay upper bits not zero");
endmodule // pleb_regs

// >>> src/pleb_top.sv
// Top of the leading-edge and state blanking block for one PWM channel.
// Assumes all inputs come from logic on clk.
`include "pleb_params.svh"
module pleb_top (
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic [`PLEB_ADDR_W-1:0]   addr,
   input  wire pleb_pkg::pleb_word_t      wr_data,
   input  wire logic                      wr_en,
   input  wire logic                      rd_en,
   output pleb_pkg::pleb_word_t           rd_data,
   input  wire logic                      high_side_output,
   input  wire logic                      low_side_output,
   input  wire logic [2:0]                gen_high_side,
   input  wire logic                      fault_in,
   input  wire logic                      climit_in,
   output logic                           fault_qual,
   output logic                           climit_qual
);
   import pleb_pkg::*;
   pleb_cfg_if cfg ();

   // Register file
   pleb_regs u_regs (
      .clk     (clk),
      .rst     (rst),
      .addr    (addr),
      .wr_data (wr_data),
      .wr_en   (wr_en),
      .rd_en   (rd_en),
      .rd_data (rd_data),
      .cfg     (cfg)
   );

   // Blanking core
   pleb_core u_core (
      .clk              (clk),
      .rst              (rst),
      .high_side_output (high_side_output),
      .low_side_output  (low_side_output),
      .gen_high_side    (gen_high_side),
      .fault_in         (fault_in),
      .climit_in        (climit_in),
      .fault_qual       (fault_qual),
      .climit_qual      (climit_qual),
      .cfg              (cfg)
   );
endmodule // pleb_top

// >>> dv/tb.sv
// Self-checking bench for the blanking block: a reference model is compared every cycle.
// Assumes pleb_pkg and the params header compile first.
`include "pleb_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pleb_pkg::*;
   logic       clk = 0, rst = 1, wr_en = 0, rd_en = 0;
   logic [3:0] addr = 4'h0;
   pleb_word_t wr_data = 16'h0000, rd_data, m_ctrl, m_dly, m_aux, exp_rd;
   logic       hs = 0, ls = 0, flt = 0, cl = 0, fq, cq, exp_f, exp_c, p_hs, p_ls;
   logic [2:0] gen = 3'h0;
   logic       src, vld, sb, msk, edg, live = 0;
   int         cnt, seed = 68278, error_cnt = 0, cmp_count = 0, cyc = 0, i, j;
   ////////////////////////////////////////////////////////////////////////
   // Clock, timeout
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc > 60000) begin
         error_cnt++;
         give_verdict();
      end
   end
   pleb_top pleb_top_inst (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .high_side_output(hs),
      .low_side_output(ls), .gen_high_side(gen), .fault_in(flt), .climit_in(cl),
      .fault_qual(fq), .climit_qual(cq));
   ////////////////////////////////////////////////////////////////////////
   // Reference model, sampled at each rising edge
   always @(posedge clk) begin
      vld = (m_aux[11:8] >= 4'h1) && (m_aux[11:8] <= 4'h3);
      src = vld ? gen[m_aux[9:8] - 2'h1] : 1'b0;
      sb = (m_ctrl[0] & ~ls) | (m_ctrl[1] & ls) | (m_ctrl[2] & ~hs) | (m_ctrl[3] & hs)
         | (vld & ((m_ctrl[4] & ~src) | (m_ctrl[5] & src)));
      msk = sb | (cnt > 0);
      edg = (m_ctrl[15] & hs & ~p_hs) | (m_ctrl[14] & ~hs & p_hs)
         | (m_ctrl[13] & ls & ~p_ls) | (m_ctrl[12] & ~ls & p_ls);
      if (rst) begin
         {m_ctrl, m_dly, m_aux, exp_rd} = '0;
         {exp_f, exp_c, p_hs, p_ls} = '0;
         cnt = 0;
         live = 1;
      end else begin
         exp_f = flt & ~msk;
         exp_c = cl & ~msk;
         // Status shows state blank and the running count before this edge
         exp_rd = !rd_en ? 16'h0000 : addr == 4'h0 ? m_ctrl : addr == 4'h1 ? m_dly
            : addr == 4'h2 ? m_aux : addr == 4'h3 ? {14'h0000, cnt > 0, sb} : 16'h0000;
         // An edge reloads the count; a zero delay ends any interval at once
         cnt = edg ? int'(m_dly) : (cnt > 0 ? cnt - 1 : 0);
         p_hs = hs;
         p_ls = ls;
         if (wr_en && addr == 4'h0) m_ctrl = wr_data & 16'hf03f;
         if (wr_en && addr == 4'h1) m_dly = wr_data & 16'h0fff;
         if (wr_en && addr == 4'h2) m_aux = wr_data & 16'h0f00;
      end
   end
   // Compare where outputs are settled
   always @(negedge clk) begin
      if (live) begin
         check(rd_data, exp_rd);
         check({15'h0000, fq}, {15'h0000, exp_f});
         check({15'h0000, cq}, {15'h0000, exp_c});
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic check(input pleb_word_t seen, input pleb_word_t want);
      cmp_count++;
      if (seen !== want) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   // One cycle of random channel levels
   task automatic step();
      logic [31:0] r;
      r = $random(seed);
      if (r[2:0] == 3'h0) hs <= ~hs;
      if (r[5:3] == 3'h0) ls <= ~ls;
      gen <= r[8:6];
      flt <= r[9] | r[10];
      cl <= r[11];
      @(posedge clk);
   endtask
   task automatic bus(input logic w, input logic rd, input logic [3:0] a,
                      input pleb_word_t d);
      wr_en <= w;
      rd_en <= rd;
      addr <= a;
      wr_data <= d;
      step();
   endtask
   task automatic idle(input int n);
      for (int k = 0; k < n; k++) bus(0, 0, addr, wr_data);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin : main
      logic [31:0] r;
      pleb_word_t  dl [4];
      dl = '{16'hf000, 16'hf001, 16'hf005, 16'hffff};
      repeat (6) @(posedge clk);
      rst <= 0;
      for (i = 0; i < 16; i++) bus(0, 1, i[3:0], 16'h0000);
      for (i = 0; i < 8; i++) bus(1, 0, i[3:0], 16'hffff);
      for (i = 0; i < 8; i++) bus(0, 1, i[3:0], 16'h0000);
      $display("test regs done");
      for (i = 0; i < 16; i++) begin
         bus(1, 0, 4'h2, pleb_word_t'(i << 8));
         bus(1, 0, 4'h0, i[0] ? 16'h0010 : 16'h0020);
         bus(0, 1, 4'h2, 16'h0000);
         idle(40);
      end
      $display("test select done");
      for (i = 0; i < 4; i++) begin
         bus(1, 0, 4'h0, pleb_word_t'(1 << i));
         idle(60);
      end
      $display("test state done");
      for (i = 0; i < 4; i++) begin
         bus(1, 0, 4'h1, dl[i]);
         for (j = 12; j < 16; j++) begin
            bus(1, 0, 4'h0, pleb_word_t'(1 << j));
            idle(i == 3 ? 4200 : 200);
         end
      end
      $display("test delay done");
      for (i = 0; i < 20000; i++) begin
         r = $random(seed);
         j = r[20] ? int'(r[19:16]) : int'(r[17:16]) % 3;
         if (j == 1 && r[21]) r[11:4] = 8'h00;
         bus(r[1:0] == 2'h0, r[1:0] == 2'h1, j[3:0], r[15:0]);
      end
      $display("test random done");
      rst <= 1;
      idle(2);
      rst <= 0;
      for (i = 0; i < 3; i++) bus(0, 1, i[3:0], 16'h0000);
      idle(2);
      $display("test reset done");
      give_verdict();
   end
endmodule // tb
